// ===== core/tpm_monitor.sv
/*
 temperature protection monitor: settings registers, one-second
 timebase and six trigger/recovery timers.
 assumes temperatures are synchronous to sys_clk, whole degrees C,
 and the register master follows the one-cycle strobe protocol.
*/
// The plain strobed port and the register offsets were chosen for this implementation.
// What this block does
// - discharge overtemp clears after max cell at or below 55 for recovery time
// - FET overtemp sets when FET temp at or above 80 for delay
// - FET overtemp delay is a byte of seconds, default 2
// - FET overtemp clears when FET temp at or below 65 long enough
// - die overtemp sets when die temp at or above signed 85 for delay
// - die overtemp delay is 0 to 255 seconds, default 2
// - die overtemp clears when die temp at or below 80 long enough
// - charge undertemp sets when min cell at or below signed 0 for delay
// - charge undertemp delay is 0 to 255 seconds, default 2
// - charge undertemp clears when min cell at or above 5 long enough
// - charge and discharge faults ignore current direction entirely
// - discharge undertemp sets when min cell at or below 0 for delay
// - discharge undertemp delay is 0 to 255 seconds, default 2
// - discharge undertemp clears when min cell at or above 5 long enough
// - die undertemp sets when die temp at or below -20 for delay
// - die undertemp delay is 0 to 255 seconds, default 2
// - die undertemp clears when die temp at or above -15 long enough
// - shared recovery time is a byte of seconds, default 3
// - discharge overtemp sets when max cell at or above 60 for delay
`include "tpm_cfg.svh"

module tpm_monitor #(
   parameter int unsigned SEC_CYCLES = `TPM_TICK_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic [`TPM_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [7:0]                  reg_rdata,
   input  wire tpm_pkg::tpm_temps_t    temps,
   output tpm_pkg::tpm_faults_t        faults
);
   import tpm_pkg::*;

   localparam logic [`TPM_SEC_W-1:0] SEC_LAST =
      `TPM_SEC_W'(SEC_CYCLES - 1);

   tpm_state_t                  st;
   tpm_state_t                  next_st;
   logic [`TPM_NUM_PROT-1:0]    fault_vec;
   logic [`TPM_NUM_PROT-1:0]    trig_c;
   logic [`TPM_NUM_PROT-1:0]    recov_c;

   // greater or equal, signed or unsigned as the setting is
   function automatic logic ge(input logic [7:0] a,
                               input logic [7:0] b,
                               input logic       sgn);
      if (sgn) begin
         return $signed(a) >= $signed(b);
      end
      return a >= b;
   endfunction

   function automatic logic [7:0] cfg_reset(input int idx);
      case (idx)
         `TPM_IDX_DSG_OT * `TPM_PROT_STRIDE: return `TPM_RST_DSG_OT_THR;
         `TPM_IDX_DSG_OT * `TPM_PROT_STRIDE + `TPM_FLD_REC:
            return `TPM_RST_DSG_OT_REC;
         `TPM_IDX_FET_OT * `TPM_PROT_STRIDE: return `TPM_RST_FET_OT_THR;
         `TPM_IDX_FET_OT * `TPM_PROT_STRIDE + `TPM_FLD_REC:
            return `TPM_RST_FET_OT_REC;
         `TPM_IDX_DIE_OT * `TPM_PROT_STRIDE: return `TPM_RST_DIE_OT_THR;
         `TPM_IDX_DIE_OT * `TPM_PROT_STRIDE + `TPM_FLD_REC:
            return `TPM_RST_DIE_OT_REC;
         `TPM_IDX_CHG_UT * `TPM_PROT_STRIDE: return `TPM_RST_CHG_UT_THR;
         `TPM_IDX_CHG_UT * `TPM_PROT_STRIDE + `TPM_FLD_REC:
            return `TPM_RST_CHG_UT_REC;
         `TPM_IDX_DSG_UT * `TPM_PROT_STRIDE: return `TPM_RST_DSG_UT_THR;
         `TPM_IDX_DSG_UT * `TPM_PROT_STRIDE + `TPM_FLD_REC:
            return `TPM_RST_DSG_UT_REC;
         `TPM_IDX_DIE_UT * `TPM_PROT_STRIDE: return `TPM_RST_DIE_UT_THR;
         `TPM_IDX_DIE_UT * `TPM_PROT_STRIDE + `TPM_FLD_REC:
            return `TPM_RST_DIE_UT_REC;
         `TPM_NUM_CFG - 1: return `TPM_RST_RECOV_TIME;
         default: return `TPM_RST_DELAY;
      endcase
   endfunction

   // keep temperature settings inside their legal range
   function automatic logic [7:0] clamp(input int idx,
                                        input logic [7:0] v);
      if (idx % `TPM_PROT_STRIDE == `TPM_FLD_DLY
          || idx == `TPM_NUM_CFG - 1) begin
         return v;
      end
      if (idx / `TPM_PROT_STRIDE == `TPM_IDX_FET_OT) begin
         return (v > `TPM_FET_MAX) ? `TPM_FET_MAX : v;
      end
      if ($signed(v) < $signed(`TPM_TEMP_MIN)) begin
         return `TPM_TEMP_MIN;
      end
      if ($signed(v) > $signed(`TPM_TEMP_MAX)) begin
         return `TPM_TEMP_MAX;
      end
      return v;
   endfunction

   // trigger and recovery conditions; current direction plays no part
   always_comb begin
      logic [7:0] v;
      logic [7:0] thr;
      logic [7:0] rec;
      logic       sgn;
      v   = 8'h00;
      thr = 8'h00;
      rec = 8'h00;
      sgn = 1'b1;
      trig_c  = '0;
      recov_c = '0;
      for (int k = 0; k < `TPM_NUM_PROT; k++) begin
         thr = st.cfg[k * `TPM_PROT_STRIDE + `TPM_FLD_THR];
         rec = st.cfg[k * `TPM_PROT_STRIDE + `TPM_FLD_REC];
         sgn = (k != `TPM_IDX_FET_OT);
         case (k)
            `TPM_IDX_DSG_OT: v = temps.cell_max;
            `TPM_IDX_FET_OT: v = temps.fet;
            `TPM_IDX_DIE_OT: v = temps.die;
            `TPM_IDX_DIE_UT: v = temps.die;
            default:         v = temps.cell_min;
         endcase
         if (k <= `TPM_IDX_DIE_OT) begin
            trig_c[k]  = ge(v, thr, sgn);
            recov_c[k] = ge(rec, v, sgn);
         end else begin
            trig_c[k]  = ge(thr, v, sgn);
            recov_c[k] = ge(v, rec, sgn);
         end
      end
   end

   // registers, timebase and read port
   always_comb begin
      next_st = st;
      // one-second tick; a slip of under a second on the first count
      // is accepted rather than restarting the divider per timer
      next_st.sec_tick = 1'b0;
      if (st.sec_cnt >= SEC_LAST) begin
         next_st.sec_cnt  = '0;
         next_st.sec_tick = 1'b1;
      end else begin
         next_st.sec_cnt = st.sec_cnt + `TPM_SEC_W'(1);
      end
      if (reg_wr && reg_addr < `TPM_ADDR_W'(`TPM_NUM_CFG)) begin
         next_st.cfg[reg_addr] = clamp(int'(reg_addr), reg_wdata);
      end
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr < `TPM_ADDR_W'(`TPM_NUM_CFG)) begin
            next_st.rdata = st.cfg[reg_addr];
         end else if (reg_addr == `TPM_REG_STATUS) begin
            next_st.rdata = {2'b00, fault_vec};
         end else if (reg_addr == `TPM_REG_COND) begin
            next_st.rdata = {2'b00, trig_c};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < `TPM_NUM_CFG; i++) begin
            st.cfg[i] <= cfg_reset(i);
         end
         st.sec_cnt  <= '0;
         st.sec_tick <= 1'b0;
         st.rdata    <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `TPM_NUM_PROT; g++) begin : gen_prot
         tpm_fault_timer u_timer (
            .sys_clk    (sys_clk),
            .rst        (rst),
            .sec_tick   (st.sec_tick),
            .trig_cond  (trig_c[g]),
            .recov_cond (recov_c[g]),
            .trig_delay (st.cfg[g * `TPM_PROT_STRIDE + `TPM_FLD_DLY]),
            .recov_time (st.cfg[`TPM_NUM_CFG - 1]),
            .fault      (fault_vec[g])
         );
      end
   endgenerate

   assign reg_rdata = st.rdata;
   assign faults    = tpm_faults_t'(fault_vec);

endmodule

// ===== pkg/tpm_cfg.svh
/*
 temperature protection monitor: register offsets, reset values,
 limits and timing figures as macros.
 assumes inclusion by bare name from the package and the core files.
*/
`ifndef TPM_CFG_SVH
`define TPM_CFG_SVH

// timebase
`define TPM_CLK_PERIOD_NS  100
`define TPM_TICK_S         1
`define TPM_TICK_CYCLES    (`TPM_TICK_S * 1000000000 / `TPM_CLK_PERIOD_NS)
`define TPM_SEC_W          24

// register map, 8-bit data, 5-bit address
`define TPM_ADDR_W         5
`define TPM_NUM_PROT       6
`define TPM_PROT_STRIDE    3
`define TPM_FLD_THR        0
`define TPM_FLD_DLY        1
`define TPM_FLD_REC        2
`define TPM_NUM_CFG        19
`define TPM_REG_RECOV_TIME 5'h12
`define TPM_REG_STATUS     5'h13
`define TPM_REG_COND       5'h14

// protection index order
`define TPM_IDX_DSG_OT     0
`define TPM_IDX_FET_OT     1
`define TPM_IDX_DIE_OT     2
`define TPM_IDX_CHG_UT     3
`define TPM_IDX_DSG_UT     4
`define TPM_IDX_DIE_UT     5

// reset values, degrees C two's complement, seconds unsigned
`define TPM_RST_DSG_OT_THR 8'h3C
`define TPM_RST_DSG_OT_REC 8'h37
`define TPM_RST_FET_OT_THR 8'h50
`define TPM_RST_FET_OT_REC 8'h41
`define TPM_RST_DIE_OT_THR 8'h55
`define TPM_RST_DIE_OT_REC 8'h50
`define TPM_RST_CHG_UT_THR 8'h00
`define TPM_RST_CHG_UT_REC 8'h05
`define TPM_RST_DSG_UT_THR 8'h00
`define TPM_RST_DSG_UT_REC 8'h05
`define TPM_RST_DIE_UT_THR 8'hEC
`define TPM_RST_DIE_UT_REC 8'hF1
`define TPM_RST_DELAY      8'h02
`define TPM_RST_RECOV_TIME 8'h03

// setting limits
`define TPM_TEMP_MIN       8'hD8
`define TPM_TEMP_MAX       8'h78
`define TPM_FET_MAX        8'h96

`endif

// ===== pkg/tpm_pkg.sv
/*
 temperature protection monitor: shared types.
 assumes tpm_cfg.svh is on the include path.
*/
`include "tpm_cfg.svh"

package tpm_pkg;

   typedef struct packed {
      logic [7:0] cell_max;
      logic [7:0] cell_min;
      logic [7:0] fet;
      logic [7:0] die;
   } tpm_temps_t;

   // bit 0 is discharge_overtemp, matching the protection index order
   typedef struct packed {
      logic die_undertemp;
      logic discharge_undertemp;
      logic charge_undertemp;
      logic die_overtemp;
      logic fet_overtemp;
      logic discharge_overtemp;
   } tpm_faults_t;

   typedef enum logic {
      TPM_CLEAR,
      TPM_TRIPPED
   } tpm_mode_t;

   typedef struct packed {
      tpm_mode_t  mode;
      logic       fault;
      logic [7:0] count;
   } tpm_tmr_state_t;

   typedef struct packed {
      logic [`TPM_NUM_CFG-1:0][7:0] cfg;
      logic [`TPM_SEC_W-1:0]        sec_cnt;
      logic                         sec_tick;
      logic [7:0]                   rdata;
   } tpm_state_t;

endpackage

// ===== core/tpm_fault_timer.sv
/*
 one protection: trigger delay then latched fault, recovery delay
 then clear, both counted in one-second ticks.
 assumes sec_tick is a one-cycle pulse once per second.
*/
`include "tpm_cfg.svh"

module tpm_fault_timer (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       sec_tick,
   input  wire logic       trig_cond,
   input  wire logic       recov_cond,
   input  wire logic [7:0] trig_delay,
   input  wire logic [7:0] recov_time,
   output logic            fault
);
   import tpm_pkg::*;

   tpm_tmr_state_t st;
   tpm_tmr_state_t next_st;

   always_comb begin
      next_st = st;
      case (st.mode)
         TPM_CLEAR: begin
            if (!trig_cond) begin
               next_st.count = 8'h00;
            end else if (st.count >= trig_delay) begin
               next_st.mode  = TPM_TRIPPED;
               next_st.fault = 1'b1;
               next_st.count = 8'h00;
            end else if (sec_tick) begin
               next_st.count = st.count + 8'h01;
            end
         end
         TPM_TRIPPED: begin
            // fault holds until recovery has lasted the full time
            if (!recov_cond) begin
               next_st.count = 8'h00;
            end else if (st.count >= recov_time) begin
               next_st.mode  = TPM_CLEAR;
               next_st.fault = 1'b0;
               next_st.count = 8'h00;
            end else if (sec_tick) begin
               next_st.count = st.count + 8'h01;
            end
         end
         default: begin
            next_st.mode  = TPM_CLEAR;
            next_st.fault = 1'b0;
            next_st.count = 8'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st.mode  <= TPM_CLEAR;
         st.fault <= 1'b0;
         st.count <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   assign fault = st.fault;

endmodule

// ===== tb/tpm_temp_src.sv
/*
 stand-in for the measurement side: registered temperature readings.
 assumes the bench writes req just after a rising edge.
*/
module tpm_temp_src (
   input  wire logic                sys_clk,
   input  wire tpm_pkg::tpm_temps_t req,
   output tpm_pkg::tpm_temps_t      temps = '0
);
   timeunit 1ns;
   timeprecision 1ns;
   import tpm_pkg::*;
   // one clock of latency, as a sampled converter would add
   always @(posedge sys_clk) begin
      temps <= req;
   end
endmodule

// ===== tb/tpm_monitor_sva.sv
/*
 port checker for the temperature monitor.
 assumes hot trigger thresholds are only ever raised and cold ones only lowered from their defaults.
*/
module tpm_monitor_sva (
   input wire logic                 sys_clk,
   input wire logic                 rst,
   input wire logic [4:0]           reg_addr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_rdata,
   input wire tpm_pkg::tpm_temps_t  temps,
   input wire tpm_pkg::tpm_faults_t faults
);
   timeunit 1ns;
   timeprecision 1ns;
   import tpm_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   status_read_a: assert property (
      $past(reg_rd) && $past(reg_addr) == 5'h13
      |-> reg_rdata == {2'b00, $past(faults)})
      else $error("status read wrong");
   // with a zero delay the fault trips on the first edge the condition
   // is seen, so only the temperature of that edge is known to qualify
   fet_rise_a: assert property ($rose(faults.fet_overtemp)
      |-> $past(temps.fet) >= 8'h50) else $error("fet fault early");
   die_rise_a: assert property ($rose(faults.die_overtemp)
      |-> $signed($past(temps.die)) >= $signed(8'h55))
      else $error("die hot fault early");
   chg_rise_a: assert property ($rose(faults.charge_undertemp)
      |-> $signed($past(temps.cell_min)) <= $signed(8'h00))
      else $error("charge cold fault early");
   fet_fall_a: assert property ($fell(faults.fet_overtemp)
      |-> $past(temps.fet) <= 8'h41) else $error("fet fault cleared hot");
   dsg_fall_a: assert property ($fell(faults.discharge_overtemp)
      |-> $signed($past(temps.cell_max)) <= $signed(8'h37))
      else $error("discharge hot fault cleared hot");
   dieut_fall_a: assert property ($fell(faults.die_undertemp)
      |-> $signed($past(temps.die)) >= $signed(8'hF1))
      else $error("die cold fault cleared cold");
endmodule
bind tpm_monitor tpm_monitor_sva u_sva (.sys_clk(sys_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .temps(temps), .faults(faults));

// ===== tb/testbench.sv
/*
 self-checking bench for the temperature monitor.
 assumes a shortened second of S clocks.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tpm_pkg::*;
   localparam int S = 8;
   logic        sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
   logic [4:0]  reg_addr = '0;
   logic [7:0]  reg_wdata = '0, reg_rdata;
   tpm_temps_t  req, temps;
   tpm_faults_t faults;
   int          mismatches = 0, cmp_count = 0, cycles = 0, seed = 37;
   int          n, d, r;
   logic [7:0]  trig[6] = '{8'h3C, 8'h50, 8'h55, 8'h00, 8'h00, 8'hEC};
   logic [7:0]  recv[6] = '{8'h37, 8'h41, 8'h50, 8'h05, 8'h05, 8'hF1};
   tpm_temp_src u_src (.sys_clk(sys_clk), .req(req), .temps(temps));
   tpm_monitor #(.SEC_CYCLES(S)) u_dut (.sys_clk(sys_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temps(temps),
      .faults(faults));
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic check(input string what, input logic [7:0] seen, e);
      cmp_count++;
      if (seen !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, e, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check("read data", reg_rdata, e);
      @(posedge sys_clk);
   endtask
   // bounded wait; n counts edges until the masked faults reach v
   task automatic wait_for(input logic [5:0] m, input logic v, output int n);
      n = 0;
      while (((faults & m) !== (v ? m : 6'h00)) && n < 5000) begin
         @(posedge sys_clk);
         #1 n++;
      end
   endtask
   task automatic set_temp(input int k, input logic [7:0] v);
      case (k)
         0: req.cell_max <= v;
         1: req.fet <= v;
         3, 4: req.cell_min <= v;
         default: req.die <= v;
      endcase
   endtask
   function automatic logic [7:0] dflt(input int a);
      if (a == 18) return 8'h03;
      if (a == 19) return 8'h00;
      case (a % 3)
         0: return trig[a / 3];
         1: return 8'h02;
         default: return recv[a / 3];
      endcase
   endfunction
   // free-running tick makes the first second partial, plus source latency
   function automatic logic [7:0] in_win(input int n, input int d);
      return 8'((n >= (d - 1) * S) && (n <= d * S + 3));
   endfunction
   initial begin
      req = {4{8'h19}};
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int a = 0; a < 20; a++) rd(5'(a), dflt(a));
      rd(5'h1F, 8'h00);
      $display("defaults done");
      for (int k = 0; k < 6; k++) begin
         d = $random(seed) & 3;
         r = $random(seed) & 3;
         wr(5'(3 * k + 1), 8'(d));
         wr(5'h12, 8'(r));
         rd(5'(3 * k + 1), 8'(d));
         wait_for(6'h3F, 1'b0, n);
         set_temp(k, trig[k]);
         wait_for(6'h01 << k, 1'b1, n);
         check("rise time", in_win(n, d), 8'h01);
         set_temp(k, recv[k]);
         wait_for(6'h01 << k, 1'b0, n);
         check("fall time", in_win(n, r), 8'h01);
         set_temp(k, 8'h19);
      end
      $display("protections done");
      wr(5'h04, 8'h02);
      repeat (2) begin
         set_temp(1, 8'h50);
         repeat (S) @(posedge sys_clk);
         set_temp(1, 8'h19);
         @(posedge sys_clk);
      end
      repeat (3) @(posedge sys_clk);
      #1 check("fet fault", 8'(faults.fet_overtemp), 8'h00);
      $display("restart done");
      wr(5'h03, 8'hC8);
      rd(5'h03, 8'h96);
      wr(5'h09, 8'hC0);
      rd(5'h09, 8'hD8);
      // top clamp on a hot threshold: a raised cold one would trip a fault
      wr(5'h00, 8'h7F);
      rd(5'h00, 8'h78);
      wr(5'h09, 8'h00);
      wr(5'h03, 8'h50);
      wr(5'h13, 8'h3F);
      rd(5'h13, 8'h00);
      $display("limits done");
      wr(5'h04, 8'h00);
      set_temp(1, 8'h50);
      wait_for(6'h02, 1'b1, n);
      check("zero delay", in_win(n, 0), 8'h01);
      rd(5'h14, 8'h02);
      rst <= 1'b1;
      set_temp(1, 8'h19);
      repeat (2) @(posedge sys_clk);
      #1 check("faults in reset", 8'(faults), 8'h00);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(5'h04, 8'h02);
      $display("reset done");
      tally_and_finish();
   end
endmodule
